// file: src/lbs_top.sv
// Indicator-light blink controller with shared-pin selection.
// Assumes pin inputs synchronous to mclk_i and a simple register port.
// Summary of operation
// RULE_01: Lit phase lasts on-time field (bits 15:8) times 4 ms.
// RULE_02: Dark phase lasts off-time field (bits 7:0) times 4 ms.
// RULE_03: Software should program on and off times above three.
// RULE_04: Blink mode 0 starts dark, then lit, repeating.
// RULE_05: Blink mode 1 starts lit, then dark, repeating.
// RULE_06: Both times zero: light follows the selected source signal live.
// RULE_07: Link-and-activity: on while link up and idle, off otherwise; code blinks on activity with link up unless both times are zero.
// RULE_08: Activity alone: off when idle, on with activity; code blinks with activity unless both times are zero.
// RULE_09: Timer output routed to RXD1, light0 or interrupt pin, or none.
// RULE_10: Capture input taken from TXD1, light1 or management pin, or none.
// RULE_11: Light1 pin carries one of seven sources; code seven disables it.
// RULE_12: Link output polarity bit selects active high or active low.
// RULE_13: A disabled channel's light stays off.
// RULE_14: Mode 0 blinks plainly; mode 1 scales blink by graded activity.
// RULE_15: Time base is a 4 ms tick; new times apply at phase boundaries.
// RULE_16: Reset reloads all fields and restarts blinking from the start phase.
`timescale 1ns/1ps
module lbs_top #(
    parameter int unsigned TICK_CYCLES = lbs_pkg::TICK_CYCLES
) (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic resetn_i,
    // Register port.
    input wire logic [15:0] mgmt_addr_i,
    input wire logic mgmt_wr_i,
    input wire logic mgmt_rd_i,
    input wire logic [15:0] mgmt_wdata_i,
    output logic [15:0] mgmt_rdata_o,
    output logic mgmt_rvalid_o,
    // Light control levels.
    input wire logic light0_enable_i,
    input wire logic light1_enable_i,
    input wire logic [1:0] blink_style_i,
    input wire logic [4:0] light0_source_select_i,
    input wire logic [4:0] light1_source_select_i,
    // Status sources.
    input wire logic link_up_i,
    input wire logic tx_activity_i,
    input wire logic rx_activity_i,
    input wire logic stamp_timer_i,
    // Functional pin sources.
    input wire logic rxd1_func_i,
    input wire logic int_n_func_i,
    input wire logic tx_er_i,
    input wire logic tx_en_i,
    input wire logic tx_clk_i,
    input wire logic txd0_i,
    input wire logic txd2_i,
    // Pins sampled for capture.
    input wire logic txd1_pin_i,
    input wire logic light1_pin_i,
    input wire logic mdio_pin_i,
    // Pin outputs.
    output logic light0_pin_o,
    output logic light1_pin_o,
    output logic light1_pin_oe_n_o,
    output logic rxd1_pin_o,
    output logic int_pin_n_o,
    output logic link_up_out_o,
    output logic stamp_capture_in_o
);
    import lbs_pkg::*;

    logic rst_s1_reg, rst_n;
    logic [15:0] pin_sel_reg;
    logic [15:0] times_reg [2];
    logic tick;
    logic [1:0] act_hold_reg;
    logic [1:0] light;
    logic [4:0] src_sel [2];
    logic [1:0] src_en;
    logic [1:0] stamp_timer_pin_sel, stamp_capture_pin_sel;
    logic [2:0] light1_pin_sel;
    logic link_out_polarity, link_up_out, light1_src;

    if (TICK_CYCLES < 2) begin : g_bad
        $error("lbs_top: TICK_CYCLES must be at least 2");
    end

    // Reset release through two flops; the assertion edge stays asynchronous.
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_s1_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_s1_reg <= 1'b1;
            rst_n <= rst_s1_reg;
        end
    end

    assign stamp_timer_pin_sel = pin_sel_reg[TMR_SEL_LSB +: 2];
    assign stamp_capture_pin_sel = pin_sel_reg[CAP_SEL_LSB +: 2];
    assign light1_pin_sel = pin_sel_reg[L1_SEL_LSB +: 3];
    assign link_out_polarity = pin_sel_reg[POL_BIT];
    assign src_sel[0] = light0_source_select_i;
    assign src_sel[1] = light1_source_select_i;
    assign src_en[0] = light0_enable_i;
    assign src_en[1] = light1_enable_i;

    // Register writes; upper pin-select bits are reserved and held at zero.
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            pin_sel_reg <= RST_PIN_SEL; // RULE_16
            times_reg[0] <= RST_TIMES;
            times_reg[1] <= RST_TIMES;
        end else if (mgmt_wr_i) begin
            unique case (mgmt_addr_i)
                REG_PIN_SEL: pin_sel_reg <= {8'h00, mgmt_wdata_i[PIN_SEL_W-1:0]};
                REG_L0_TIMES: times_reg[0] <= mgmt_wdata_i;
                REG_L1_TIMES: times_reg[1] <= mgmt_wdata_i;
                default: ;
            endcase
        end
    end

    // Read data one cycle after the strobe; unmapped addresses read zero.
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            mgmt_rdata_o <= 16'h0000;
            mgmt_rvalid_o <= 1'b0;
        end else begin
            mgmt_rvalid_o <= mgmt_rd_i;
            if (mgmt_rd_i) begin
                unique case (mgmt_addr_i)
                    REG_PIN_SEL: mgmt_rdata_o <= pin_sel_reg;
                    REG_L0_TIMES: mgmt_rdata_o <= times_reg[0];
                    REG_L1_TIMES: mgmt_rdata_o <= times_reg[1];
                    default: mgmt_rdata_o <= 16'h0000;
                endcase
            end
        end
    end

    // Shared 4 ms time base for both channels.
    lbs_tick #(.DIV(TICK_CYCLES)) u_tick ( // RULE_15
        .clk_i(mclk_i),
        .rst_n_i(rst_n),
        .tick_o(tick)
    );

    lbs_chan_if cif [2] ();

    // Per-channel source decode and blink channel.
    for (genvar c = 0; c < 2; c++) begin : g_ch
        logic act, link_fn, act_fn, on_fn, blink_fn, live;
        // Short activity pulses are stretched to a tick so blinking can start.
        always_ff @(posedge mclk_i or negedge rst_n) begin
            if (!rst_n) begin
                act_hold_reg[c] <= 1'b0;
            end else begin
                act_hold_reg[c] <= act | (act_hold_reg[c] & ~tick);
            end
        end
        always_comb begin
            act = 1'b0;
            link_fn = 1'b0;
            act_fn = 1'b0;
            on_fn = 1'b0;
            blink_fn = 1'b0;
            unique case (src_sel[c])
                SRC_LINK_TXRX: begin
                    link_fn = 1'b1;
                    act = tx_activity_i | rx_activity_i;
                end
                SRC_LINK_TX: begin
                    link_fn = 1'b1;
                    act = tx_activity_i;
                end
                SRC_LINK_RX: begin
                    link_fn = 1'b1;
                    act = rx_activity_i;
                end
                SRC_LINK_ONLY: link_fn = 1'b1;
                SRC_TXRX: begin
                    act_fn = 1'b1;
                    act = tx_activity_i | rx_activity_i;
                end
                SRC_TX: begin
                    act_fn = 1'b1;
                    act = tx_activity_i;
                end
                SRC_RX: begin
                    act_fn = 1'b1;
                    act = rx_activity_i;
                end
                SRC_BLINK: blink_fn = 1'b1;
                SRC_ON: on_fn = 1'b1;
                default: ;
            endcase
        end
        assign live = (times_reg[c] == 16'h0000); // RULE_06
        assign cif[c].tick = tick;
        assign cif[c].enable = src_en[c];
        assign cif[c].style = blink_style_i[c]; // RULE_14
        assign cif[c].live = live;
        assign cif[c].activity = act;
        assign cif[c].on_ticks = times_reg[c][ON_LSB +: 8];
        assign cif[c].off_ticks = times_reg[c][OFF_LSB +: 8];
        // Link plus activity: lit when up and idle, blinks while up with activity unless live, dark otherwise.
        assign cif[c].level = on_fn | blink_fn | (link_fn & link_up_i & ~act) // RULE_07
                              | (act_fn & act); // RULE_08
        assign cif[c].blink_req = !live && (blink_fn
                                  || (act_fn && act_hold_reg[c]) // RULE_08
                                  || (link_fn && link_up_i && act_hold_reg[c])); // RULE_07
        assign light[c] = cif[c].light;
        lbs_chan u_chan (
            .clk_i(mclk_i),
            .rst_n_i(rst_n),
            .cif(cif[c])
        );
    end

    assign link_up_out = link_up_i ^ link_out_polarity; // RULE_12

    // Second light pin source selection.
    always_comb begin
        unique case (light1_pin_sel) // RULE_11
            L1_LIGHT: light1_src = light[1];
            L1_TX_ER: light1_src = tx_er_i;
            L1_TX_EN: light1_src = tx_en_i;
            L1_TX_CLK: light1_src = tx_clk_i;
            L1_TXD0: light1_src = txd0_i;
            L1_TXD2: light1_src = txd2_i;
            L1_LINK: light1_src = link_up_out;
            default: light1_src = 1'b0;
        endcase
    end

    // Registered pin drivers; the capture selection releases the light1 pin.
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            light0_pin_o <= 1'b0;
            light1_pin_o <= 1'b0;
            light1_pin_oe_n_o <= 1'b1;
            rxd1_pin_o <= 1'b0;
            int_pin_n_o <= 1'b1;
            link_up_out_o <= 1'b0;
        end else begin
            rxd1_pin_o <= (stamp_timer_pin_sel == TMR_RXD1) ? stamp_timer_i : rxd1_func_i;
            light0_pin_o <= (stamp_timer_pin_sel == TMR_LIGHT0) ? stamp_timer_i : light[0];
            int_pin_n_o <= (stamp_timer_pin_sel == TMR_INT) ? stamp_timer_i : int_n_func_i;
            light1_pin_o <= light1_src; // RULE_11
            light1_pin_oe_n_o <= (light1_pin_sel == L1_OFF)
                                 || (stamp_capture_pin_sel == CAP_LIGHT1);
            link_up_out_o <= link_up_out; // RULE_12
        end
    end

    // Capture input selection; unassigned codes give a quiet low.
    always_ff @(posedge mclk_i or negedge rst_n) begin
        if (!rst_n) begin
            stamp_capture_in_o <= 1'b0;
        end else begin
            unique case (stamp_capture_pin_sel) // RULE_10
                CAP_TXD1: stamp_capture_in_o <= txd1_pin_i;
                CAP_LIGHT1: stamp_capture_in_o <= light1_pin_i;
                CAP_MDIO: stamp_capture_in_o <= mdio_pin_i;
                default: stamp_capture_in_o <= 1'b0;
            endcase
        end
    end

    chk_timer_route: assert property (@(posedge mclk_i) disable iff (!rst_n) // RULE_09
        (stamp_timer_pin_sel == TMR_LIGHT0) |=> light0_pin_o == $past(stamp_timer_i))
        else $error("timer not routed to light0 pin");
    chk_timer_int: assert property (@(posedge mclk_i) disable iff (!rst_n) // RULE_09
        (stamp_timer_pin_sel != TMR_INT) |=> int_pin_n_o == $past(int_n_func_i))
        else $error("interrupt pin taken by timer when not selected");
    chk_capture_mdio: assert property (@(posedge mclk_i) disable iff (!rst_n) // RULE_10
        (stamp_capture_pin_sel == CAP_MDIO) |=> stamp_capture_in_o == $past(mdio_pin_i))
        else $error("capture not taken from management pin");
    chk_light1_off: assert property (@(posedge mclk_i) disable iff (!rst_n) // RULE_11
        (light1_pin_sel == L1_OFF) |=> light1_pin_oe_n_o)
        else $error("light1 pin driven while disabled");
    chk_link_polarity: assert property (@(posedge mclk_i) disable iff (!rst_n) // RULE_12
        ##1 link_up_out_o == ($past(link_up_i) ^ $past(link_out_polarity)))
        else $error("link output polarity wrong");
    chk_reset_fields: assert property (@(posedge mclk_i) disable iff (!rst_n) // RULE_16
        $rose(rst_n) |-> (pin_sel_reg == RST_PIN_SEL && times_reg[1] == RST_TIMES))
        else $error("fields not at reset values after reset");
endmodule // lbs_top

// file: src/lbs_pkg.sv
// Shared constants for the indicator-light blinker and pin selection.
// Assumes a single 250 MHz clock and a 16-bit management register port.
package lbs_pkg;
    // Clock and blink time base.
    localparam int unsigned CLK_HZ = 250_000_000;
    localparam int unsigned TICK_MS = 4;
    localparam int unsigned TICK_CYCLES = (CLK_HZ / 1000) * TICK_MS;
    // Activity grading: window of 640 ms, ten grades of 10 percent.
    localparam int unsigned WINDOW_MS = 640;
    localparam int unsigned WINDOW_TICKS = WINDOW_MS / TICK_MS;
    localparam int unsigned GRADE_MAX = 10;
    localparam int unsigned GRADE_STEP_TICKS = WINDOW_TICKS / GRADE_MAX;
    localparam logic [3:0] TENTHS = 4'ha;
    // Register offsets and reset values.
    localparam logic [15:0] REG_PIN_SEL = 16'h8c56;
    localparam logic [15:0] REG_L0_TIMES = 16'h8c80;
    localparam logic [15:0] REG_L1_TIMES = 16'h8c81;
    localparam logic [15:0] RST_PIN_SEL = 16'h00fe;
    localparam logic [15:0] RST_TIMES = 16'h3636;
    // Field positions.
    localparam int unsigned ON_LSB = 8;
    localparam int unsigned OFF_LSB = 0;
    localparam int unsigned TMR_SEL_LSB = 6;
    localparam int unsigned CAP_SEL_LSB = 4;
    localparam int unsigned L1_SEL_LSB = 1;
    localparam int unsigned POL_BIT = 0;
    localparam int unsigned PIN_SEL_W = 8;
    // Pin select codes.
    localparam logic [1:0] TMR_RXD1 = 2'h0;
    localparam logic [1:0] TMR_LIGHT0 = 2'h1;
    localparam logic [1:0] TMR_INT = 2'h2;
    localparam logic [1:0] CAP_TXD1 = 2'h0;
    localparam logic [1:0] CAP_LIGHT1 = 2'h1;
    localparam logic [1:0] CAP_MDIO = 2'h2;
    localparam logic [2:0] L1_LIGHT = 3'h0;
    localparam logic [2:0] L1_TX_ER = 3'h1;
    localparam logic [2:0] L1_TX_EN = 3'h2;
    localparam logic [2:0] L1_TX_CLK = 3'h3;
    localparam logic [2:0] L1_TXD0 = 3'h4;
    localparam logic [2:0] L1_TXD2 = 3'h5;
    localparam logic [2:0] L1_LINK = 3'h6;
    localparam logic [2:0] L1_OFF = 3'h7;
    // Light source functions.
    localparam logic [4:0] SRC_LINK_TXRX = 5'h00;
    localparam logic [4:0] SRC_LINK_TX = 5'h01;
    localparam logic [4:0] SRC_LINK_RX = 5'h02;
    localparam logic [4:0] SRC_LINK_ONLY = 5'h03;
    localparam logic [4:0] SRC_TXRX = 5'h04;
    localparam logic [4:0] SRC_TX = 5'h05;
    localparam logic [4:0] SRC_RX = 5'h06;
    localparam logic [4:0] SRC_BLINK = 5'h07;
    localparam logic [4:0] SRC_ON = 5'h08;
    // Blink phase.
    typedef enum logic [1:0] {PH_DARK = 2'b01, PH_LIT = 2'b10} lbs_phase_t;
endpackage

// file: src/lbs_chan_if.sv
// Interface between the light controller and one blink channel.
// Assumes both ends share the system clock.
`timescale 1ns/1ps
interface lbs_chan_if;
    logic tick;
    logic enable;
    logic style;
    logic live;
    logic level;
    logic blink_req;
    logic activity;
    logic [7:0] on_ticks;
    logic [7:0] off_ticks;
    logic light;
    modport ctrl (output tick, enable, style, live, level, blink_req, activity,
                  output on_ticks, off_ticks, input light);
    modport chan (input tick, enable, style, live, level, blink_req, activity,
                  input on_ticks, off_ticks, output light);
endinterface

// file: src/lbs_tick.sv
// Divider that gives a one-cycle pulse every DIV clocks.
// Assumes an asynchronous active-low reset.
`timescale 1ns/1ps
module lbs_tick #(
    parameter int unsigned DIV = lbs_pkg::TICK_CYCLES
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Tick.
    output logic tick_o
);
    import lbs_pkg::*;
    localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
    logic [CW-1:0] cnt_reg;

    if (DIV < 2) begin : g_bad
        $error("lbs_tick: DIV must be at least 2");
    end

    // Free-running count; the pulse marks its wrap.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_reg <= '0;
            tick_o <= 1'b0;
        end else begin
            tick_o <= (cnt_reg == CW'(DIV - 1));
            cnt_reg <= (cnt_reg == CW'(DIV - 1)) ? '0 : cnt_reg + 1'b1;
        end
    end
endmodule // lbs_tick

// file: src/lbs_chan.sv
// One blink channel: phase timing, activity grading and the light level.
// Assumes the tick pulse and configuration come through lbs_chan_if.
`timescale 1ns/1ps
module lbs_chan (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Controller side.
    lbs_chan_if.chan cif
);
    import lbs_pkg::*;
    lbs_phase_t phase_reg;
    logic [12:0] acc_reg;
    logic [7:0] on_lat_reg, off_lat_reg, win_reg, act_cnt_reg, nt_reg;
    logic [3:0] grade_reg, g;
    logic style_lat_reg, seen_reg, end_ph, armed_reg, restart;
    logic [12:0] on_lim, off_lim, acc_add;

    // Mode 1 shortens lit and lengthens dark in tenths as activity grows.
    assign g = style_lat_reg ? grade_reg : 4'h0; // RULE_14
    assign on_lim = 13'(on_lat_reg) * 13'(TENTHS - g); // RULE_01
    assign off_lim = 13'(off_lat_reg) * (13'(TENTHS) + 13'(g)); // RULE_02
    assign acc_add = acc_reg + 13'(TENTHS);
    assign restart = !cif.blink_req || !armed_reg; // First run after reset restarts too.
    assign end_ph = cif.tick && (acc_add >= ((phase_reg == PH_LIT) ? on_lim : off_lim));

    // Phase sequencer; new times are taken only at a phase boundary.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            phase_reg <= PH_DARK; // RULE_16
            acc_reg <= '0;
            on_lat_reg <= RST_TIMES[ON_LSB +: 8];
            off_lat_reg <= RST_TIMES[OFF_LSB +: 8];
            style_lat_reg <= 1'b0;
            armed_reg <= 1'b0;
        end else if (restart || end_ph) begin
            armed_reg <= cif.blink_req;
            if (restart) begin
                phase_reg <= cif.style ? PH_LIT : PH_DARK; // RULE_04 RULE_05
            end else begin
                phase_reg <= (phase_reg == PH_LIT) ? PH_DARK : PH_LIT;
            end
            acc_reg <= '0;
            on_lat_reg <= cif.on_ticks; // RULE_15
            off_lat_reg <= cif.off_ticks;
            style_lat_reg <= cif.style;
        end else if (cif.tick) begin
            acc_reg <= acc_add;
        end
    end

    // Activity grading over a fixed window; a tick with any activity counts.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            seen_reg <= 1'b0;
            win_reg <= '0;
            act_cnt_reg <= '0;
            grade_reg <= '0;
        end else begin
            seen_reg <= cif.activity | (seen_reg & ~cif.tick);
            if (cif.tick) begin
                if (win_reg == 8'(WINDOW_TICKS - 1)) begin
                    win_reg <= '0;
                    act_cnt_reg <= '0;
                    grade_reg <= 4'(act_cnt_reg / 8'(GRADE_STEP_TICKS)); // RULE_14
                end else begin
                    win_reg <= win_reg + 1'b1;
                    act_cnt_reg <= act_cnt_reg + 8'(seen_reg | cif.activity);
                end
            end
        end
    end

    // Light level: disabled is dark, live or no blink request follows the source, else the phase.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cif.light <= 1'b0;
        end else if (!cif.enable) begin
            cif.light <= 1'b0; // RULE_13
        end else if (cif.live || !cif.blink_req) begin
            cif.light <= cif.level; // RULE_06
        end else begin
            cif.light <= (phase_reg == PH_LIT);
        end
    end

    // Helper: ticks spent in the current phase.
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            nt_reg <= '0;
        end else if (restart || end_ph) begin
            nt_reg <= '0;
        end else if (cif.tick) begin
            nt_reg <= nt_reg + 1'b1;
        end
    end

    chk_lit_length: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_01
        (end_ph && !restart && phase_reg == PH_LIT && !style_lat_reg && on_lat_reg != 0)
        |-> (nt_reg + 8'h01) == on_lat_reg)
        else $error("lit phase length differs from on ticks");
    chk_dark_length: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_02
        (end_ph && !restart && phase_reg == PH_DARK && !style_lat_reg && off_lat_reg != 0)
        |-> (nt_reg + 8'h01) == off_lat_reg)
        else $error("dark phase length differs from off ticks");
    chk_start_dark: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_04
        (restart && !cif.style) |=> phase_reg == PH_DARK)
        else $error("mode 0 does not start dark");
    chk_start_lit: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_05
        (restart && cif.style) |=> phase_reg == PH_LIT)
        else $error("mode 1 does not start lit");
    chk_live_follow: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_06
        (cif.enable && cif.live) |=> cif.light == $past(cif.level))
        else $error("live monitor does not follow source");
    chk_disabled_dark: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RULE_13
        !cif.enable |=> !cif.light)
        else $error("disabled light is lit");
endmodule // lbs_chan

// file: tb/led_blink_and_pin_select_test.sv
// Self-checking bench for the light blinker and shared-pin selection.
// Assumes lbs_top with a short tick so that blink phases last a few dozen cycles.
`timescale 1ns/1ps
module led_blink_and_pin_select_test;
    import lbs_pkg::*;
    localparam int unsigned TK = 8;
    logic mclk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic [15:0] mgmt_addr_i = 16'h0, mgmt_wdata_i = 16'h0;
    logic mgmt_wr_i = 1'b0, mgmt_rd_i = 1'b0, light0_enable_i = 1'b1, light1_enable_i = 1'b1;
    logic [1:0] blink_style_i = 2'h2;
    logic [4:0] light0_source_select_i = SRC_BLINK, light1_source_select_i = SRC_BLINK;
    logic link_up_i = 1'b0, tx_activity_i = 1'b0, rx_activity_i = 1'b0, stamp_timer_i = 1'b0;
    logic rxd1_func_i = 1'b0, int_n_func_i = 1'b0;
    logic [6:0] pat = 7'h0;
    logic [2:0] cap = 3'h0;
    logic [15:0] mgmt_rdata_o;
    logic mgmt_rvalid_o, light0_pin_o, light1_pin_o, light1_pin_oe_n_o, rxd1_pin_o;
    logic int_pin_n_o, link_up_out_o, stamp_capture_in_o;
    int n_fail = 0, n_tests = 0, cyc = 0;
    logic [15:0] expq[$];

    lbs_top #(.TICK_CYCLES(TK)) dut_u (
        .mclk_i(mclk_i), .resetn_i(resetn_i), .mgmt_addr_i(mgmt_addr_i),
        .mgmt_wr_i(mgmt_wr_i), .mgmt_rd_i(mgmt_rd_i), .mgmt_wdata_i(mgmt_wdata_i),
        .mgmt_rdata_o(mgmt_rdata_o), .mgmt_rvalid_o(mgmt_rvalid_o),
        .light0_enable_i(light0_enable_i), .light1_enable_i(light1_enable_i),
        .blink_style_i(blink_style_i), .light0_source_select_i(light0_source_select_i),
        .light1_source_select_i(light1_source_select_i), .link_up_i(link_up_i),
        .tx_activity_i(tx_activity_i), .rx_activity_i(rx_activity_i),
        .stamp_timer_i(stamp_timer_i), .rxd1_func_i(rxd1_func_i), .int_n_func_i(int_n_func_i),
        .tx_er_i(pat[1]), .tx_en_i(pat[2]), .tx_clk_i(pat[3]), .txd0_i(pat[4]), .txd2_i(pat[5]),
        .txd1_pin_i(cap[0]), .light1_pin_i(cap[1]), .mdio_pin_i(cap[2]),
        .light0_pin_o(light0_pin_o), .light1_pin_o(light1_pin_o),
        .light1_pin_oe_n_o(light1_pin_oe_n_o), .rxd1_pin_o(rxd1_pin_o),
        .int_pin_n_o(int_pin_n_o), .link_up_out_o(link_up_out_o),
        .stamp_capture_in_o(stamp_capture_in_o)
    );

    // Free-running 250 MHz clock.
    always #2 mclk_i = ~mclk_i;

    // Inputs move one nanosecond after the edge, so no sampling race is possible.
    task automatic step(input int n);
        repeat (n) @(posedge mclk_i);
        #1;
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // The extra idle cycle keeps a following strobe from landing in the same step.
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        mgmt_addr_i = a;
        mgmt_wdata_i = d;
        mgmt_wr_i = 1'b1;
        step(1);
        mgmt_wr_i = 1'b0;
        step(1);
    endtask
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        expq.push_back(e);
        mgmt_addr_i = a;
        mgmt_rd_i = 1'b1;
        step(1);
        mgmt_rd_i = 1'b0;
        step(1);
    endtask
    function automatic logic [15:0] ps(input logic [1:0] t, input logic [1:0] c,
            input logic [2:0] l, input logic p);
        return {8'h00, t, c, l, p};
    endfunction
    // Waits for the light to reach a level, then counts how long it stays there.
    task automatic run_len(input logic lv, output int n);
        n = 0;
        while (light0_pin_o !== lv && n < 3000) begin
            n++;
            step(1);
        end
        n = 0;
        while (light0_pin_o === lv && n < 3000) begin
            n++;
            step(1);
        end
    endtask
    task automatic watch(input int n, output logic any1, output logic all1);
        any1 = 1'b0;
        all1 = 1'b1;
        repeat (n) begin
            any1 |= light0_pin_o;
            all1 &= light0_pin_o;
            step(1);
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Read results are compared against the oldest expectation noted by the driver.
    always @(negedge mclk_i) begin
        if (mgmt_rvalid_o === 1'b1) begin
            chk(mgmt_rdata_o, expq.pop_front());
        end
    end

    // A hang counts as a mismatch; the run needs only about a thousand cycles.
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            end_sim();
        end
    end

    // Main sequence.
    initial begin
        int n;
        logic a1, l1;
        logic [15:0] r;
        void'($urandom(44152));
        step(4);
        resetn_i = 1'b1;
        step(4);
        rd(REG_PIN_SEL, RST_PIN_SEL);
        rd(REG_L0_TIMES, RST_TIMES);
        rd(REG_L1_TIMES, RST_TIMES);
        rd(16'h8c57, 16'h0000);
        wr(REG_PIN_SEL, 16'hff00 | ps(2'h3, 2'h3, L1_LIGHT, 1'b0));
        rd(REG_PIN_SEL, ps(2'h3, 2'h3, L1_LIGHT, 1'b0));
        chk(light0_pin_o, 1'b0);
        chk(light1_pin_o, 1'b1);
        r = 16'($urandom);
        wr(REG_L1_TIMES, r);
        rd(REG_L1_TIMES, r);
        $display("test registers done");
        light0_enable_i = 1'b0;
        stamp_timer_i = 1'b1;
        for (int c = 0; c < 4; c++) begin
            wr(REG_PIN_SEL, ps(c[1:0], 2'h3, L1_OFF, 1'b0));
            chk(rxd1_pin_o, c == 0);
            chk(light0_pin_o, c == 1);
            chk(int_pin_n_o, c == 2);
            for (int b = 0; b < 3; b++) begin
                cap = 3'h1 << b;
                wr(REG_PIN_SEL, ps(2'h3, c[1:0], L1_LIGHT, 1'b0));
                chk(stamp_capture_in_o, c < 3 && cap[c]);
                chk(light1_pin_oe_n_o, c == 1);
            end
            link_up_i = c[0];
            wr(REG_PIN_SEL, ps(2'h3, 2'h3, L1_OFF, c[1]));
            chk(link_up_out_o, c[0] ^ c[1]);
        end
        for (int k = 1; k < 8; k++) begin
            for (int v = 0; v < 2; v++) begin
                pat = v ? ~(7'h1 << k) : 7'h1 << k;
                link_up_i = pat[6];
                wr(REG_PIN_SEL, ps(2'h3, 2'h3, k[2:0], 1'b0));
                chk(light1_pin_oe_n_o, k == 7);
                chk(light1_pin_o, k < 7 && v == 0);
            end
        end
        watch(100, a1, l1);
        chk(a1, 1'b0);
        $display("test pin select done");
        light0_enable_i = 1'b1;
        wr(REG_L0_TIMES, 16'h0405);
        run_len(1'b0, n);
        run_len(1'b1, n);
        chk(16'(n), 16'(4 * TK));
        run_len(1'b0, n);
        chk(16'(n), 16'(5 * TK));
        $display("test blink timing done");
        light0_source_select_i = SRC_LINK_TXRX;
        link_up_i = 1'b1;
        step(60);
        chk(light0_pin_o, 1'b1);
        tx_activity_i = 1'b1;
        watch(100, a1, l1);
        chk(l1, 1'b0);
        tx_activity_i = 1'b0;
        link_up_i = 1'b0;
        step(60);
        chk(light0_pin_o, 1'b0);
        light0_source_select_i = SRC_TX;
        step(60);
        chk(light0_pin_o, 1'b0);
        tx_activity_i = 1'b1;
        watch(100, a1, l1);
        chk(a1, 1'b1);
        tx_activity_i = 1'b0;
        light0_source_select_i = SRC_TXRX;
        step(60);
        wr(REG_L0_TIMES, 16'h0000);
        step(5);
        rx_activity_i = 1'b1;
        step(3);
        chk(light0_pin_o, 1'b1);
        rx_activity_i = 1'b0;
        step(3);
        chk(light0_pin_o, 1'b0);
        $display("test light sources done");
        end_sim();
    end
endmodule // led_blink_and_pin_select_test
